// ---- src/itp_dev_end.sv ----
`include "itp_cfg.svh"
module itp_dev_end
  import itp_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   rst,
  itp_stream_if.dev                   port,
  input  wire logic                   rawFmt,
  input  wire logic                   crfEn,
  input  wire logic [`ITP_ID_W-1:0]   localId,
  output logic                        txValid,
  input  wire logic                   txReady,
  output logic [`ITP_DATA_W-1:0]      txData,
  output logic [`ITP_KEEP_W-1:0]      txKeep,
  output logic                        txLast,
  output logic [`ITP_USER_W-1:0]      txUser,
  output logic                        txResp,
  input  wire logic                   rxValid,
  output logic                        rxReady,
  input  wire logic [`ITP_DATA_W-1:0] rxData,
  input  wire logic [`ITP_KEEP_W-1:0] rxKeep,
  input  wire logic                   rxLast,
  input  wire logic                   rxResp,
  input  wire logic                   rxCrf,
  input  wire logic [`ITP_ID_W-1:0]   rxSrcId,
  input  wire logic [`ITP_ID_W-1:0]   rxDstId
);
  itp_dev_s  state_reg;
  itp_dev_s  state_next;
  logic      txInValid;
  logic      txInReady;
  itp_beat_s txInBeat;
  itp_beat_s txOutBeat;
  logic      irespInValid;
  logic      irespInReady;
  logic      treqInValid;
  logic      treqInReady;
  itp_beat_s rxBeat;
  itp_beat_s irespBeat;
  itp_beat_s treqBeat;
  logic      rxRouteResp;

  // =====================================================
  // Transmit side: packet-wise choice of initiator or target response
  always_comb begin
    state_next    = state_reg;
    txInValid     = 1'b0;
    txInBeat      = '0;
    port.ireq_tready  = 1'b0;
    port.tresp_tready = 1'b0;
    case (state_reg.txSel)
      TX_IDLE: begin
        // Initiator first; target answers wait while initiator requests keep coming
        if (port.ireq_tvalid) begin
          state_next.txSel = TX_IREQ;
        end else if (port.tresp_tvalid) begin
          state_next.txSel = TX_TRSP;
        end
      end
      TX_IREQ: begin
        txInValid        = port.ireq_tvalid;
        port.ireq_tready = txInReady;
        txInBeat.resp    = 1'b0;
        txInBeat.data    = port.ireq_tdata;
        txInBeat.last    = port.ireq_tlast;
        txInBeat.keep    = rawFmt ? port.ireq_tkeep : `ITP_KEEP_ALL;
        if (state_reg.txFirst) begin
          if (rawFmt) begin
            txInBeat.user[`ITP_CRF_BIT] = port.ireq_tuser[`ITP_CRF_BIT] & crfEn;
          end else begin
            txInBeat.user = {localId, port.ireq_tuser[`ITP_SRC_LO-1:0]};
          end
        end
      end
      TX_TRSP: begin
        txInValid         = port.tresp_tvalid;
        port.tresp_tready = txInReady;
        txInBeat.resp     = 1'b1;
        txInBeat.data     = port.tresp_tdata;
        txInBeat.last     = port.tresp_tlast;
        txInBeat.keep     = rawFmt ? port.tresp_tkeep : `ITP_KEEP_ALL;
        if (state_reg.txFirst) begin
          txInBeat.user = rawFmt ? {24'h0, 6'h0, port.tresp_tuser[`ITP_CRF_BIT] & crfEn, 1'b0}
                                 : port.tresp_tuser;
        end
      end
      default: begin
        state_next.txSel = TX_IDLE;
      end
    endcase
    if (txInValid && txInReady) begin
      state_next.txFirst = 1'b0;
      if (txInBeat.last) begin
        state_next.txFirst = 1'b1;
        state_next.txSel   = TX_IDLE;
      end
    end
    // =====================================================
    // Receive side: route by packet kind, decided on the first beat
    rxRouteResp = state_reg.rxFirst ? rxResp : state_reg.rxResp;
    rxBeat      = '0;
    rxBeat.resp = rxRouteResp;
    rxBeat.data = rxData;
    rxBeat.last = rxLast;
    // Keep all ones except raw last
    rxBeat.keep = (rawFmt && rxLast) ? rxKeep : `ITP_KEEP_ALL;
    if (state_reg.rxFirst) begin
      if (rawFmt) begin
        rxBeat.user[`ITP_CRF_BIT] = rxCrf;
      end else begin
        rxBeat.user = {rxSrcId, rxDstId};
      end
    end
    irespInValid = rxValid && rxRouteResp;
    treqInValid  = rxValid && !rxRouteResp;
    rxReady      = rxRouteResp ? irespInReady : treqInReady;
    if (rxValid && rxReady) begin
      state_next.rxFirst = rxLast;
      state_next.rxResp  = rxRouteResp;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= '{txSel: TX_IDLE, txFirst: 1'b1, rxFirst: 1'b1, rxResp: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  // =====================================================
  // Output stages: one per channel; both receive stages share the rx input, so a stall on one blocks the other
  // Held until accepted
  itp_beat_reg txStage (
    .mclk     (mclk),
    .rst      (rst),
    .inValid  (txInValid),
    .inReady  (txInReady),
    .inBeat   (txInBeat),
    .outValid (txValid),
    .outReady (txReady),
    .outBeat  (txOutBeat)
  );

  itp_beat_reg irespStage (
    .mclk     (mclk),
    .rst      (rst),
    .inValid  (irespInValid),
    .inReady  (irespInReady),
    .inBeat   (rxBeat),
    .outValid (port.iresp_tvalid),
    .outReady (port.iresp_tready),
    .outBeat  (irespBeat)
  );

  itp_beat_reg treqStage (
    .mclk     (mclk),
    .rst      (rst),
    .inValid  (treqInValid),
    .inReady  (treqInReady),
    .inBeat   (rxBeat),
    .outValid (port.treq_tvalid),
    .outReady (port.treq_tready),
    .outBeat  (treqBeat)
  );

  assign txData           = txOutBeat.data;
  assign txKeep           = txOutBeat.keep;
  assign txLast           = txOutBeat.last;
  assign txUser           = txOutBeat.user;
  assign txResp           = txOutBeat.resp;
  assign port.iresp_tdata = irespBeat.data;
  assign port.iresp_tkeep = irespBeat.keep;
  assign port.iresp_tlast = irespBeat.last;
  assign port.iresp_tuser = irespBeat.user;
  assign port.treq_tdata  = treqBeat.data;
  assign port.treq_tkeep  = treqBeat.keep;
  assign port.treq_tlast  = treqBeat.last;
  assign port.treq_tuser  = treqBeat.user;
endmodule // itp_dev_end

// ---- src/itp_cfg.svh ----
`ifndef ITP_CFG_SVH
`define ITP_CFG_SVH
// =====================================================
// Widths and field positions
`define ITP_DATA_W     64
`define ITP_KEEP_W     8
`define ITP_USER_W     32
`define ITP_ID_W       16
`define ITP_KEEP_ALL   8'hFF
`define ITP_CRF_BIT    1
`define ITP_SRC_LO     16
`define ITP_ID8_MASK   16'h00FF
// =====================================================
// Register offsets of the user end
`define ITP_OFS_CTRL   8'h00
`define ITP_OFS_IDS    8'h04
`define ITP_OFS_DLO    8'h08
`define ITP_OFS_DHI    8'h0C
`define ITP_OFS_SEND   8'h10
`define ITP_OFS_STAT   8'h14
`define ITP_OFS_RLO    8'h18
`define ITP_OFS_RHI    8'h1C
`define ITP_OFS_THDR   8'h20
`define ITP_CTRL_RAW   0
`define ITP_CTRL_CRF   1
`define ITP_CTRL_ID8   2
`endif

// ---- src/itp_pkg.sv ----
`include "itp_cfg.svh"
package itp_pkg;
  typedef struct packed {
    logic                   resp;
    logic [`ITP_DATA_W-1:0] data;
    logic [`ITP_KEEP_W-1:0] keep;
    logic                   last;
    logic [`ITP_USER_W-1:0] user;
  } itp_beat_s;
  // Gray along idle -> initiator -> target response
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_IREQ = 2'b01,
    TX_TRSP = 2'b11
  } itp_tx_e;
  typedef struct packed {
    itp_tx_e txSel;
    logic    txFirst;
    logic    rxFirst;
    logic    rxResp;
  } itp_dev_s;
  typedef struct packed {
    logic                   valid;
    itp_beat_s              beat;
  } itp_slot_s;
endpackage

// ---- src/itp_stream_if.sv ----
`include "itp_cfg.svh"
interface itp_stream_if;
  logic                   ireq_tvalid,  ireq_tready,  ireq_tlast;
  logic [`ITP_DATA_W-1:0] ireq_tdata;
  logic [`ITP_KEEP_W-1:0] ireq_tkeep;
  logic [`ITP_USER_W-1:0] ireq_tuser;
  logic                   iresp_tvalid, iresp_tready, iresp_tlast;
  logic [`ITP_DATA_W-1:0] iresp_tdata;
  logic [`ITP_KEEP_W-1:0] iresp_tkeep;
  logic [`ITP_USER_W-1:0] iresp_tuser;
  logic                   treq_tvalid,  treq_tready,  treq_tlast;
  logic [`ITP_DATA_W-1:0] treq_tdata;
  logic [`ITP_KEEP_W-1:0] treq_tkeep;
  logic [`ITP_USER_W-1:0] treq_tuser;
  logic                   tresp_tvalid, tresp_tready, tresp_tlast;
  logic [`ITP_DATA_W-1:0] tresp_tdata;
  logic [`ITP_KEEP_W-1:0] tresp_tkeep;
  logic [`ITP_USER_W-1:0] tresp_tuser;
  modport dev (
    input  ireq_tvalid, ireq_tdata, ireq_tkeep, ireq_tlast, ireq_tuser,
    output ireq_tready,
    output iresp_tvalid, iresp_tdata, iresp_tkeep, iresp_tlast, iresp_tuser,
    input  iresp_tready,
    output treq_tvalid, treq_tdata, treq_tkeep, treq_tlast, treq_tuser,
    input  treq_tready,
    input  tresp_tvalid, tresp_tdata, tresp_tkeep, tresp_tlast, tresp_tuser,
    output tresp_tready
  );
  modport usr (
    output ireq_tvalid, ireq_tdata, ireq_tkeep, ireq_tlast, ireq_tuser,
    input  ireq_tready,
    input  iresp_tvalid, iresp_tdata, iresp_tkeep, iresp_tlast, iresp_tuser,
    output iresp_tready,
    input  treq_tvalid, treq_tdata, treq_tkeep, treq_tlast, treq_tuser,
    output treq_tready,
    output tresp_tvalid, tresp_tdata, tresp_tkeep, tresp_tlast, tresp_tuser,
    input  tresp_tready
  );
endinterface

// ---- src/itp_beat_reg.sv ----
// =====================================================
// One-beat register stage; data leaves from flip-flops
module itp_beat_reg
  import itp_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      rst,
  input  wire logic      inValid,
  output logic           inReady,
  input  wire itp_beat_s inBeat,
  output logic           outValid,
  input  wire logic      outReady,
  output itp_beat_s      outBeat
);
  itp_slot_s slot_reg;
  itp_slot_s slot_next;

  // Refill in the same cycle the held beat leaves, so full rate is kept
  assign inReady  = !slot_reg.valid || outReady;
  assign outValid = slot_reg.valid;
  assign outBeat  = slot_reg.beat;

  always_comb begin
    slot_next = slot_reg;
    if (outReady) begin
      slot_next.valid = 1'b0;
    end
    if (inValid && inReady) begin
      slot_next.valid = 1'b1;
      slot_next.beat  = inBeat;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      slot_reg <= '0;
    end else begin
      slot_reg <= slot_next;
    end
  end
endmodule // itp_beat_reg

// ---- src/itp_usr_end.sv ----
`include "itp_cfg.svh"
module itp_usr_end
  import itp_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  itp_stream_if.usr        port,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  typedef struct packed {
    logic [2:0]  ctrl;
    logic [31:0] ids;
    logic [63:0] data;
    logic [31:0] thdr;
    itp_slot_s   ireq;
    logic        ireqFirst;
    itp_slot_s   tresp;
    logic        treqFirst;
    logic [31:0] treqIds;
    logic [63:0] respData;
    logic [7:0]  irespPkts;
    logic [7:0]  treqPkts;
  } itp_usr_s;
  itp_usr_s    st_reg;
  itp_usr_s    st_next;
  logic        access;
  logic        raw;
  logic        id8;
  logic [15:0] srcId;
  logic [15:0] dstId;

  assign access = psel && penable;
  assign raw    = st_reg.ctrl[`ITP_CTRL_RAW];
  assign id8    = st_reg.ctrl[`ITP_CTRL_ID8];
  assign srcId  = id8 ? (st_reg.ids[31:16] & `ITP_ID8_MASK) : st_reg.ids[31:16];
  assign dstId  = id8 ? (st_reg.ids[15:0] & `ITP_ID8_MASK) : st_reg.ids[15:0];

  // =====================================================
  // Register bus; a send waits while the previous beat is still held
  always_comb begin
    st_next = st_reg;
    pready  = 1'b1;
    pslverr = 1'b0;
    prdata  = 32'h0;
    case (paddr)
      `ITP_OFS_CTRL: prdata = {29'h0, st_reg.ctrl};
      `ITP_OFS_IDS:  prdata = st_reg.ids;
      `ITP_OFS_DLO:  prdata = st_reg.data[31:0];
      `ITP_OFS_DHI:  prdata = st_reg.data[63:32];
      `ITP_OFS_SEND: pready = !(pwrite && st_reg.ireq.valid);
      `ITP_OFS_STAT: prdata = {8'h0, st_reg.treqPkts, st_reg.irespPkts, 7'h0, st_reg.ireq.valid};
      `ITP_OFS_RLO:  prdata = st_reg.respData[31:0];
      `ITP_OFS_RHI:  prdata = st_reg.respData[63:32];
      `ITP_OFS_THDR: prdata = st_reg.thdr;
      default:       pslverr = 1'b1;
    endcase
    if (st_reg.ireq.valid && port.ireq_tready) begin
      st_next.ireq.valid = 1'b0;
      st_next.ireqFirst  = st_reg.ireq.beat.last;
    end
    if (access && pwrite && pready) begin
      case (paddr)
        `ITP_OFS_CTRL: st_next.ctrl = pwdata[2:0];
        `ITP_OFS_IDS:  st_next.ids = pwdata;
        `ITP_OFS_DLO:  st_next.data[31:0] = pwdata;
        `ITP_OFS_DHI:  st_next.data[63:32] = pwdata;
        `ITP_OFS_THDR: st_next.thdr = pwdata;
        `ITP_OFS_SEND: begin
          st_next.ireq.valid     = 1'b1;
          st_next.ireq.beat.data = st_reg.data;
          st_next.ireq.beat.last = pwdata[0];
          st_next.ireq.beat.keep = (raw && pwdata[0]) ? pwdata[15:8] : `ITP_KEEP_ALL;
          st_next.ireq.beat.user = '0;
          if (st_next.ireqFirst) begin
            st_next.ireq.beat.user = raw ? {30'h0, st_reg.ctrl[`ITP_CTRL_CRF], 1'b0}
                                         : {srcId, dstId};
          end
        end
        default: begin
        end
      endcase
    end
    // =====================================================
    // Response sink always ready; count packets, keep the last beat
    if (port.iresp_tvalid) begin
      st_next.respData = port.iresp_tdata;
      if (port.iresp_tlast) begin
        st_next.irespPkts = st_reg.irespPkts + 8'h01;
      end
    end
    // =====================================================
    // Target requests answered by a one-beat response: own source id, requester's id as destination in header format; raw user is zero
    if (st_reg.tresp.valid && port.tresp_tready) begin
      st_next.tresp.valid = 1'b0;
    end
    if (port.treq_tvalid && !st_reg.tresp.valid) begin
      st_next.treqFirst = port.treq_tlast;
      if (st_reg.treqFirst) begin
        st_next.treqIds = port.treq_tuser;
      end
      if (port.treq_tlast) begin
        st_next.treqPkts         = st_reg.treqPkts + 8'h01;
        st_next.tresp.valid      = 1'b1;
        st_next.tresp.beat.data  = {32'h0, st_reg.thdr};
        st_next.tresp.beat.last  = 1'b1;
        st_next.tresp.beat.keep  = `ITP_KEEP_ALL;
        st_next.tresp.beat.user  = raw ? 32'h0 : {srcId, (st_reg.treqFirst ?
                                   port.treq_tuser[31:16] : st_reg.treqIds[31:16])};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg           <= '0;
      st_reg.ireqFirst <= 1'b1;
      st_reg.treqFirst <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign port.ireq_tvalid  = st_reg.ireq.valid;
  assign port.ireq_tdata   = st_reg.ireq.beat.data;
  assign port.ireq_tkeep   = st_reg.ireq.beat.keep;
  assign port.ireq_tlast   = st_reg.ireq.beat.last;
  assign port.ireq_tuser   = st_reg.ireq.beat.user;
  assign port.iresp_tready = 1'b1;
  assign port.treq_tready  = !st_reg.tresp.valid;
  assign port.tresp_tvalid = st_reg.tresp.valid;
  assign port.tresp_tdata  = st_reg.tresp.beat.data;
  assign port.tresp_tkeep  = st_reg.tresp.beat.keep;
  assign port.tresp_tlast  = st_reg.tresp.beat.last;
  assign port.tresp_tuser  = st_reg.tresp.beat.user;
endmodule // itp_usr_end

// ---- verif/itp_checker.sv ----
`include "itp_cfg.svh"
// =====================================================
// Stream checker on the joint interface
module itp_checker (
  input wire logic                   mclk,
  input wire logic                   rst,
  input wire logic                   rawFmt,
  input wire logic                   ireq_tvalid,
  input wire logic                   ireq_tready,
  input wire logic                   ireq_tlast,
  input wire logic [`ITP_DATA_W-1:0] ireq_tdata,
  input wire logic [`ITP_KEEP_W-1:0] ireq_tkeep,
  input wire logic                   iresp_tvalid,
  input wire logic                   iresp_tready,
  input wire logic                   iresp_tlast,
  input wire logic [`ITP_KEEP_W-1:0] iresp_tkeep,
  input wire logic [`ITP_USER_W-1:0] iresp_tuser,
  input wire logic                   treq_tvalid,
  input wire logic                   treq_tready,
  input wire logic                   treq_tlast,
  input wire logic [`ITP_KEEP_W-1:0] treq_tkeep,
  input wire logic                   tresp_tvalid,
  input wire logic                   tresp_tready,
  input wire logic [`ITP_DATA_W-1:0] tresp_tdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  logic respFirst;
  // =====================================================
  // Packet start tracking; tuser only counts on the first beat
  always_ff @(posedge mclk) begin
    if (rst) respFirst <= 1'b1;
    else if (iresp_tvalid && iresp_tready) respFirst <= iresp_tlast;
  end
  sequence treq_end_s;
    treq_tvalid && treq_tready && treq_tlast;
  endsequence
  sequence tresp_up_s;
    ##[1:16] tresp_tvalid;
  endsequence
  // =====================================================
  // Assertions
  reset_idle_a: assert property ($fell(rst) |-> !ireq_tvalid && !iresp_tvalid && !treq_tvalid)
    else $error("valid raised straight after reset");
  ireq_hold_a: assert property (ireq_tvalid && !ireq_tready |=> ireq_tvalid
    && $stable(ireq_tdata) && $stable(ireq_tkeep) && $stable(ireq_tlast))
    else $error("request beat changed while stalled");
  tresp_hold_a: assert property (tresp_tvalid && !tresp_tready |=> tresp_tvalid
    && $stable(tresp_tdata)) else $error("response beat changed while stalled");
  ireq_keep_a: assert property (!rawFmt && ireq_tvalid |-> ireq_tkeep == 8'hFF)
    else $error("request keep not all ones");
  resp_keep_a: assert property (iresp_tvalid && (!rawFmt || !iresp_tlast)
    |-> iresp_tkeep == 8'hFF) else $error("response keep not all ones");
  treq_keep_a: assert property (treq_tvalid && (!rawFmt || !treq_tlast)
    |-> treq_tkeep == 8'hFF) else $error("target request keep not all ones");
  later_user_a: assert property (iresp_tvalid && !respFirst |-> iresp_tuser == 32'h0)
    else $error("user field set on a later beat");
  raw_user_a: assert property (rawFmt && iresp_tvalid |-> iresp_tuser[31:2] == 30'h0
    && !iresp_tuser[0]) else $error("raw user field has reserved bits");
  ireq_progress_a: assert property (ireq_tvalid |-> ##[0:40] ireq_tready)
    else $error("request never taken");
  treq_answer_a: assert property (treq_end_s |-> tresp_up_s)
    else $error("target request left unanswered");
endmodule // itp_checker

// ---- verif/initiator_target_io_port_tb.sv ----
`include "itp_cfg.svh"
// =====================================================
// Bench: APB user end facing the device end
module initiator_target_io_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   mclk = 1'b0, rst = 1'b1, rawFmt = 1'b0, crfEn = 1'b0, stallOn = 1'b0;
  logic                   rxValid = 1'b0, rxLast = 1'b0, rxResp = 1'b0, rxCrf = 1'b0;
  logic                   psel = 1'b0, penable = 1'b0, pwrite = 1'b0, txReady = 1'b0;
  logic                   pready, pslverr, txValid, txLast, txResp, rxReady, err;
  logic [`ITP_ID_W-1:0]   localId = 16'h0A5C, rxSrcId = 16'h0, rxDstId = 16'h0;
  logic [`ITP_DATA_W-1:0] rxData = 64'h0, txData;
  logic [`ITP_KEEP_W-1:0] rxKeep = 8'hFF, txKeep;
  logic [`ITP_USER_W-1:0] txUser;
  logic [7:0]             paddr = 8'h00;
  logic [31:0]            pwdata = 32'h0, prdata, rd;
  logic [1:0]             cyc = 2'b00;
  logic [105:0]           txQ[$];
  logic [104:0]           rspQ[$];
  int                     n_mismatch = 0, check_count = 0;

  itp_stream_if sif ();
  itp_dev_end itp_dev_end_inst (.mclk(mclk), .rst(rst), .port(sif.dev), .rawFmt(rawFmt),
    .crfEn(crfEn), .localId(localId), .txValid(txValid), .txReady(txReady), .txData(txData),
    .txKeep(txKeep), .txLast(txLast), .txUser(txUser), .txResp(txResp), .rxValid(rxValid),
    .rxReady(rxReady), .rxData(rxData), .rxKeep(rxKeep), .rxLast(rxLast), .rxResp(rxResp),
    .rxCrf(rxCrf), .rxSrcId(rxSrcId), .rxDstId(rxDstId));
  itp_usr_end itp_usr_end_inst (.mclk(mclk), .rst(rst), .port(sif.usr), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  itp_checker itp_checker_inst (.mclk(mclk), .rst(rst), .rawFmt(rawFmt),
    .ireq_tvalid(sif.ireq_tvalid), .ireq_tready(sif.ireq_tready), .ireq_tlast(sif.ireq_tlast),
    .ireq_tdata(sif.ireq_tdata), .ireq_tkeep(sif.ireq_tkeep), .iresp_tvalid(sif.iresp_tvalid),
    .iresp_tready(sif.iresp_tready), .iresp_tlast(sif.iresp_tlast),
    .iresp_tkeep(sif.iresp_tkeep), .iresp_tuser(sif.iresp_tuser), .treq_tvalid(sif.treq_tvalid),
    .treq_tready(sif.treq_tready), .treq_tlast(sif.treq_tlast), .treq_tkeep(sif.treq_tkeep),
    .tresp_tvalid(sif.tresp_tvalid), .tresp_tready(sif.tresp_tready),
    .tresp_tdata(sif.tresp_tdata));

  initial begin
    forever #2 mclk = ~mclk;
  end
  // =====================================================
  // Link side: stall one cycle in four, log beats seen
  always @(posedge mclk) begin
    cyc <= cyc + 2'd1;
    txReady <= !stallOn || cyc != 2'd0;
    if (txValid && txReady) txQ.push_back({txResp, txLast, txKeep, txUser, txData});
    if (sif.iresp_tvalid && sif.iresp_tready)
      rspQ.push_back({sif.iresp_tlast, sif.iresp_tkeep, sif.iresp_tuser, sif.iresp_tdata});
  end
  // =====================================================
  // Tasks
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic hang();
    n_mismatch++;
    report_and_stop();
  endtask
  task automatic check(input logic [127:0] seen, input logic [127:0] want);
    check_count++;
    if (seen !== want) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(posedge mclk);
      if (pready) break;
    end
    if (i == 64) hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Caller stands just after a clock edge; valid drops only after the last beat
  task automatic rxBeat(input logic [63:0] d, input logic [7:0] k, input logic l);
    int i;
    rxValid <= 1'b1;
    rxData <= d;
    rxKeep <= k;
    rxLast <= l;
    for (i = 0; i < 64; i++) begin
      @(posedge mclk);
      if (rxReady) break;
    end
    if (i == 64) hang();
    if (l) rxValid <= 1'b0;
  endtask
  task automatic waitFor(input int n, input bit rsp);
    int i;
    for (i = 0; i < 200; i++) begin
      if ((rsp ? rspQ.size() : txQ.size()) >= n) break;
      @(posedge mclk);
    end
    if (i == 200) hang();
  endtask
  // =====================================================
  // Main sequence
  initial begin
    int b;
    logic [127:0] want;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    stallOn <= 1'b1;
    apb(1'b1, `ITP_OFS_CTRL, 32'h0);
    apb(1'b1, `ITP_OFS_IDS, 32'h1234_0056);
    for (b = 0; b < 2; b++) begin
      apb(1'b1, `ITP_OFS_DLO, 32'h0BAD_0000 + b);
      apb(1'b1, `ITP_OFS_DHI, 32'h5EED_0000 + b);
      apb(1'b1, `ITP_OFS_SEND, b);
    end
    waitFor(2, 1'b0);
    for (b = 0; b < 2; b++) begin
      want = {1'b0, b[0], 8'hFF, (b == 0) ? {localId, 16'h0056} : 32'h0,
              32'h5EED_0000 + b, 32'h0BAD_0000 + b};
      check(txQ.pop_front(), want);
    end
    $display("header request test done");
    rawFmt <= 1'b1;
    for (b = 0; b < 2; b++) begin
      crfEn <= (b == 0);
      apb(1'b1, `ITP_OFS_CTRL, 32'h3);
      apb(1'b1, `ITP_OFS_SEND, 32'h0F01);
      waitFor(1, 1'b0);
      check(txQ.pop_front(), {2'b01, 8'h0F, (b == 0) ? 32'h2 : 32'h0, 64'h5EED_0001_0BAD_0001});
    end
    $display("raw request test done");
    stallOn <= 1'b0;
    rawFmt <= 1'b0;
    apb(1'b1, `ITP_OFS_CTRL, 32'h0);
    rxResp <= 1'b1;
    rxCrf <= 1'b1;
    rxSrcId <= 16'h00AB;
    rxDstId <= 16'h0A5C;
    rxBeat(64'h1111_2222_3333_4444, 8'hFF, 1'b0);
    rxBeat(64'h5555_6666_7777_8888, 8'h0F, 1'b1);
    waitFor(2, 1'b1);
    check(rspQ.pop_front(), {1'b0, 8'hFF, 32'h00AB_0A5C, 64'h1111_2222_3333_4444});
    check(rspQ.pop_front(), {1'b1, 8'hFF, 32'h0, 64'h5555_6666_7777_8888});
    apb(1'b0, `ITP_OFS_RHI, 32'h0);
    check(rd, 32'h5555_6666);
    crfEn <= 1'b1;
    rawFmt <= 1'b1;
    apb(1'b1, `ITP_OFS_CTRL, 32'h1);
    rxBeat(64'hA5, 8'h3C, 1'b1);
    waitFor(1, 1'b1);
    check(rspQ.pop_front(), {1'b1, 8'h3C, 32'h2, 64'hA5});
    $display("response delivery test done");
    rawFmt <= 1'b0;
    apb(1'b1, `ITP_OFS_CTRL, 32'h0);
    apb(1'b1, `ITP_OFS_THDR, 32'hCAFE_0001);
    rxResp <= 1'b0;
    rxSrcId <= 16'h0077;
    rxBeat(64'h9, 8'hFF, 1'b1);
    waitFor(1, 1'b0);
    want = txQ.pop_front();
    check(want[105:0], {2'b11, 8'hFF, 16'h1234, 16'h0077, 64'h0000_0000_CAFE_0001});
    apb(1'b0, `ITP_OFS_STAT, 32'h0);
    check(rd[23:0], 24'h01_02_00);
    $display("target request test done");
    // Short identifiers: upper byte of the destination id must go out as zero
    apb(1'b1, `ITP_OFS_CTRL, 32'h4);
    apb(1'b1, `ITP_OFS_IDS, 32'h1234_7856);
    apb(1'b1, `ITP_OFS_SEND, 32'h1);
    waitFor(1, 1'b0);
    check(txQ.pop_front(), {2'b01, 8'hFF, localId, 16'h0056, 64'h5EED_0001_0BAD_0001});
    $display("short identifier test done");
    // Unmapped place must refuse and leave the map untouched
    apb(1'b1, 8'h40, 32'hFFFF_FFFF);
    apb(1'b0, 8'h40, 32'h0);
    check({err, rd}, {1'b1, 32'h0});
    apb(1'b0, `ITP_OFS_CTRL, 32'h0);
    check(rd, 32'h4);
    $display("register map test done");
    report_and_stop();
  end
endmodule // initiator_target_io_port_tb
